// file: shared/dsw_defines.vh
`ifndef DSW_DEFINES_VH
`define DSW_DEFINES_VH

// register offsets (byte addresses)
`define DSW_OFF_CTRL 12'h000
`define DSW_OFF_STATUS 12'h004
`define DSW_OFF_MATCH 12'h008
`define DSW_OFF_DIVISOR 12'h00C

// status field positions
`define DSW_ST_ADDR_LSB 0
`define DSW_ST_ADDR_MSB 4
`define DSW_ST_RATE_LSB 5
`define DSW_ST_RATE_MSB 6
`define DSW_ST_TEST_BIT 7
`define DSW_ST_ADDR_BAD_BIT 8
`define DSW_ST_RATE_BAD_BIT 9
`define DSW_ST_VALID_BIT 10

// control field positions and reset
`define DSW_CTRL_LED_EN_BIT 0
`define DSW_CTRL_RESET 1'b1

// rate codes {high, low}
`define DSW_RATE_9600 2'b00
`define DSW_RATE_19200 2'b01

// timing
`define DSW_CLK_HZ 25000000
`define DSW_SYNC_SETTLE 2'd2
`define DSW_BAUD_SLOW 9600
`define DSW_BAUD_FAST 19200
`define DSW_LED_STEP_MS 1000
`define DSW_LED_STEP_CYC (`DSW_CLK_HZ / 1000 * `DSW_LED_STEP_MS)
`define DSW_DIV_SLOW (`DSW_CLK_HZ / `DSW_BAUD_SLOW)
`define DSW_DIV_FAST (`DSW_CLK_HZ / `DSW_BAUD_FAST)

`endif

// file: core/dsw_config_decoder.v
`include "dsw_defines.vh"

// Function
// - act only as slave, answer only frames carrying own station address
// - address is binary of first five switches, switch one is bit zero
// - switches six and seven pick rate: both off 9600, only six on 19200
// - switch eight off gives normal operation, on gives self-test
// - self-test lights red, yellow, green, about one second each, in turn
module dsw_config_decoder #(
	parameter LED_STEP_CYC = `DSW_LED_STEP_CYC
) (
	// apb
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// dip switches
	input wire addr_switch_bit0,
	input wire addr_switch_bit1,
	input wire addr_switch_bit2,
	input wire addr_switch_bit3,
	input wire addr_switch_bit4,
	input wire rate_select_low,
	input wire rate_select_high,
	input wire selftest_select,
	// link side address check
	input wire [4:0] frame_addr,
	input wire frame_addr_valid,
	output reg frame_accept,
	// decoded configuration
	output reg [4:0] station_addr,
	output reg [15:0] baud_divisor,
	output reg fast_rate,
	output reg normal_mode,
	output reg selftest_mode,
	output reg config_valid,
	// indicators
	output reg led_red,
	output reg led_yellow,
	output reg led_green
);

	// indicator walk states
	localparam ST_IDLE = 2'd0;
	localparam ST_RED = 2'd1;
	localparam ST_YELLOW = 2'd2;
	localparam ST_GREEN = 2'd3;

	localparam integer DIV_SLOW_INT = `DSW_DIV_SLOW;
	localparam integer DIV_FAST_INT = `DSW_DIV_FAST;
	// divisor is clock over baud, truncated to the register width
	localparam [15:0] DIV_SLOW = DIV_SLOW_INT[15:0];
	localparam [15:0] DIV_FAST = DIV_FAST_INT[15:0];

	wire [7:0] sw_raw;
	reg [7:0] sw_meta_reg;
	reg [7:0] sw_sync_reg;
	reg [1:0] settle_reg;
	reg sampled_reg;
	reg [7:0] sw_held_reg;
	reg addr_bad_reg;
	reg rate_bad_reg;
	reg led_en_reg;
	reg [1:0] led_state_reg;
	reg [1:0] led_state_next;
	reg [31:0] led_cnt_reg;
	reg [31:0] match_cnt_reg;
	reg [31:0] rdata_next;
	wire apb_setup;
	wire apb_write;
	wire ctrl_write;
	wire frame_hit;
	wire led_run;
	wire led_step_done;

	function rd_mapped;
		input [11:0] a;
		begin
			rd_mapped = (a == `DSW_OFF_CTRL) || (a == `DSW_OFF_STATUS) ||
				(a == `DSW_OFF_MATCH) || (a == `DSW_OFF_DIVISOR);
		end
	endfunction

	function rate_is_fast;
		input [1:0] code;
		begin
			rate_is_fast = (code == `DSW_RATE_19200);
		end
	endfunction

	function rate_is_legal;
		input [1:0] code;
		begin
			rate_is_legal = (code == `DSW_RATE_9600) || (code == `DSW_RATE_19200);
		end
	endfunction

	// switch eight is the msb, switch one the lsb
	assign sw_raw = {selftest_select, rate_select_high, rate_select_low, addr_switch_bit4,
		addr_switch_bit3, addr_switch_bit2, addr_switch_bit1, addr_switch_bit0};
	assign apb_setup = psel && !penable;
	assign apb_write = psel && penable && pready && pwrite;
	// read-only registers and unmapped offsets ignore writes
	assign ctrl_write = apb_write && (paddr == `DSW_OFF_CTRL);
	// a frame counts only in normal mode with a legal own address
	assign frame_hit = frame_addr_valid && normal_mode && !addr_bad_reg &&
		(frame_addr == station_addr);
	// the walk runs only while self-test is decoded and software allows it
	assign led_run = selftest_mode && led_en_reg;
	assign led_step_done = (led_cnt_reg == LED_STEP_CYC - 1);

	// two flops per switch; switches are not timed to pclk
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_meta_reg <= 8'h00;
			sw_sync_reg <= 8'h00;
		end else begin
			sw_meta_reg <= sw_raw;
			sw_sync_reg <= sw_meta_reg;
		end
	end

	// one-time capture after release, once the synchroniser has filled
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle_reg <= 2'd0;
			sampled_reg <= 1'b0;
			sw_held_reg <= 8'h00;
		end else if (!sampled_reg) begin
			if (settle_reg == `DSW_SYNC_SETTLE) begin
				sampled_reg <= 1'b1;
				sw_held_reg <= sw_sync_reg;
			end else begin
				settle_reg <= settle_reg + 2'd1;
			end
		end
	end

	// decode, registered; stays constant after capture
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			station_addr <= 5'd0;
			baud_divisor <= 16'h0000;
			fast_rate <= 1'b0;
			normal_mode <= 1'b0;
			selftest_mode <= 1'b0;
			config_valid <= 1'b0;
		end else begin
			station_addr <= sw_held_reg[4:0];
			fast_rate <= rate_is_fast(sw_held_reg[6:5]);
			// reserved codes fall back to the slow divisor
			if (rate_is_fast(sw_held_reg[6:5])) begin
				baud_divisor <= DIV_FAST;
			end else begin
				baud_divisor <= DIV_SLOW;
			end
			normal_mode <= sampled_reg && !sw_held_reg[7];
			selftest_mode <= sampled_reg && sw_held_reg[7];
			config_valid <= sampled_reg;
		end
	end

	// installer errors, reported in status; a zero address also blocks frame_hit
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_bad_reg <= 1'b0;
			rate_bad_reg <= 1'b0;
		end else begin
			addr_bad_reg <= sampled_reg && (sw_held_reg[4:0] == 5'd0);
			rate_bad_reg <= sampled_reg && !rate_is_legal(sw_held_reg[6:5]);
		end
	end

	// slave address filter; never accepts in self-test or reserved address
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_accept <= 1'b0;
			match_cnt_reg <= 32'h0000_0000;
		end else begin
			frame_accept <= frame_hit;
			if (frame_hit) begin
				match_cnt_reg <= match_cnt_reg + 32'h0000_0001;
			end
		end
	end

	// self-test indicator walk: red, yellow, green, repeat
	always @* begin
		led_state_next = led_state_reg;
		case (led_state_reg)
			ST_IDLE: begin
				if (led_run) begin
					led_state_next = ST_RED;
				end
			end
			ST_RED: begin
				if (led_step_done) begin
					led_state_next = ST_YELLOW;
				end
			end
			ST_YELLOW: begin
				if (led_step_done) begin
					led_state_next = ST_GREEN;
				end
			end
			default: begin
				if (led_step_done) begin
					led_state_next = ST_RED;
				end
			end
		endcase
		if (!led_run) begin
			led_state_next = ST_IDLE;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			led_state_reg <= ST_IDLE;
			led_cnt_reg <= 32'h0000_0000;
			led_red <= 1'b0;
			led_yellow <= 1'b0;
			led_green <= 1'b0;
		end else begin
			led_state_reg <= led_state_next;
			// step counter restarts on every state change
			if (led_state_next != led_state_reg) begin
				led_cnt_reg <= 32'h0000_0000;
			end else if (led_state_reg != ST_IDLE) begin
				led_cnt_reg <= led_cnt_reg + 32'h0000_0001;
			end
			// leds follow the next state so they change with the state register
			led_red <= (led_state_next == ST_RED);
			led_yellow <= (led_state_next == ST_YELLOW);
			led_green <= (led_state_next == ST_GREEN);
		end
	end

	// apb read mux
	// status shows the captured rate switches so a reserved code is visible
	always @* begin
		rdata_next = 32'h0000_0000;
		if (paddr == `DSW_OFF_CTRL) begin
			rdata_next[`DSW_CTRL_LED_EN_BIT] = led_en_reg;
		end else if (paddr == `DSW_OFF_STATUS) begin
			rdata_next[`DSW_ST_ADDR_MSB:`DSW_ST_ADDR_LSB] = station_addr;
			rdata_next[`DSW_ST_RATE_MSB:`DSW_ST_RATE_LSB] = sw_held_reg[6:5];
			rdata_next[`DSW_ST_TEST_BIT] = selftest_mode;
			rdata_next[`DSW_ST_ADDR_BAD_BIT] = addr_bad_reg;
			rdata_next[`DSW_ST_RATE_BAD_BIT] = rate_bad_reg;
			rdata_next[`DSW_ST_VALID_BIT] = config_valid;
		end else if (paddr == `DSW_OFF_MATCH) begin
			rdata_next = match_cnt_reg;
		end else if (paddr == `DSW_OFF_DIVISOR) begin
			rdata_next[15:0] = baud_divisor;
		end
	end

	// no wait state: pready rises in the first access cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= apb_setup;
		end
	end

	// error flag stands with pready for an unmapped offset
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= apb_setup && !rd_mapped(paddr);
		end
	end

	// read data captured at setup; writes return zero
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (apb_setup) begin
			if (pwrite) begin
				prdata <= 32'h0000_0000;
			end else begin
				prdata <= rdata_next;
			end
		end
	end

	// led enable, written in the access cycle the slave completes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			led_en_reg <= `DSW_CTRL_RESET;
		end else if (ctrl_write) begin
			led_en_reg <= pwdata[`DSW_CTRL_LED_EN_BIT];
		end
	end

endmodule // dsw_config_decoder

// file: dv/dsw_config_decoder_assertions.sv
module dsw_chk (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// switches
	input wire logic addr_switch_bit0,
	input wire logic addr_switch_bit1,
	input wire logic addr_switch_bit2,
	input wire logic addr_switch_bit3,
	input wire logic addr_switch_bit4,
	input wire logic rate_select_low,
	input wire logic rate_select_high,
	input wire logic selftest_select,
	// frame filter
	input wire logic [4:0] frame_addr,
	input wire logic frame_addr_valid,
	input wire logic frame_accept,
	// decoded
	input wire logic [4:0] station_addr,
	input wire logic fast_rate,
	input wire logic normal_mode,
	input wire logic selftest_mode,
	input wire logic config_valid,
	// leds
	input wire logic led_red,
	input wire logic led_yellow,
	input wire logic led_green
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire hit = frame_addr_valid && frame_addr == station_addr && normal_mode && |station_addr;
	chk_accept_own: assert property (1 |=> frame_accept == $past(hit))
		else $error("frame accept wrong");
	chk_addr_switches: assert property ($rose(config_valid) |-> station_addr ==
		{addr_switch_bit4, addr_switch_bit3, addr_switch_bit2, addr_switch_bit1, addr_switch_bit0})
		else $error("station address wrong");
	chk_rate_pick: assert property ($rose(config_valid) |->
		fast_rate == (rate_select_low && !rate_select_high)) else $error("rate wrong");
	chk_mode_pick: assert property ($rose(config_valid) |->
		selftest_mode == selftest_select && normal_mode == !selftest_select)
		else $error("mode wrong");
	chk_red_first: assert property ($rose(selftest_mode) |=> led_red && !led_yellow)
		else $error("red not first");
	chk_led_single: assert property ($onehot0({led_red, led_yellow, led_green}))
		else $error("several leds lit");
	chk_cfg_held: assert property (config_valid |=>
		config_valid && $stable({station_addr, fast_rate, normal_mode}))
		else $error("configuration moved");
	cover property (frame_accept);
	cover property ($rose(led_green));
	cover property ($rose(config_valid) && fast_rate);
endmodule // dsw_chk

bind dsw_config_decoder dsw_chk u_chk (.*);

// file: dv/dsw_host_model.sv
module dsw_host_model (
	// clock
	input wire logic pclk,
	// frame address
	output logic [4:0] frame_addr,
	output logic frame_addr_valid
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		frame_addr = 5'h1f;
		frame_addr_valid = 1'b0;
	end
	// one addressed frame, line then shows the inverted address
	task automatic send(input logic [4:0] a);
		frame_addr <= a;
		frame_addr_valid <= 1'b1;
		@(posedge pclk);
		frame_addr <= ~a;
		frame_addr_valid <= 1'b0;
	endtask
endmodule // dsw_host_model

// file: dv/tb_dsw_config_decoder.sv
module tb_dsw_config_decoder;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic addr_switch_bit0, addr_switch_bit1, addr_switch_bit2, addr_switch_bit3;
	logic addr_switch_bit4, rate_select_low, rate_select_high, selftest_select;
	logic [4:0] frame_addr, station_addr;
	logic frame_addr_valid, frame_accept, fast_rate, normal_mode, selftest_mode, config_valid;
	logic [15:0] baud_divisor;
	logic led_red, led_yellow, led_green;
	wire [2:0] leds = {led_red, led_yellow, led_green};
	int n_mismatch = 0;
	int n_compared = 0;
	always #20 pclk = ~pclk;
	dsw_host_model host (.*);
	dsw_config_decoder #(.LED_STEP_CYC(8)) uut (.*);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		$display("compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rst(input logic [7:0] s);
		presetn <= 1'b0;
		{selftest_select, rate_select_high, rate_select_low, addr_switch_bit4, addr_switch_bit3,
			addr_switch_bit2, addr_switch_bit1, addr_switch_bit0} <= s;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (5) @(posedge pclk);
	endtask
	task automatic t_normal;
		rst(8'h35);
		check(32'(config_valid), 32'h0000_0001);
		check(32'(station_addr), 32'h0000_0015);
		check(32'(baud_divisor), 32'h0000_0516);
		check(32'({fast_rate, normal_mode, selftest_mode}), 32'h0000_0006);
		apb(1'b0, 12'h004, 32'h0000_0000);
		check(q, 32'h0000_0435);
		apb(1'b0, 12'h000, 32'h0000_0000);
		check(q, 32'h0000_0001);
		host.send(5'h15);
		@(posedge pclk);
		check(32'(frame_accept), 32'h0000_0001);
		host.send(5'h14);
		@(posedge pclk);
		check(32'(frame_accept), 32'h0000_0000);
		apb(1'b0, 12'h008, 32'h0000_0000);
		check(q, 32'h0000_0001);
		{selftest_select, rate_select_low, addr_switch_bit0} <= 3'b101;
		repeat (4) @(posedge pclk);
		check(32'({station_addr, normal_mode}), 32'h0000_002b);
		apb(1'b0, 12'h010, 32'h0000_0000);
		check(32'(err), 32'h0000_0001);
		check(q, 32'h0000_0000);
		$display("normal test done");
	endtask
	task automatic t_selftest;
		int n;
		rst(8'h83);
		while (leds !== 3'b100) @(posedge pclk);
		for (int i = 0; i < 3; i++) begin
			n = 0;
			while (leds === (3'b100 >> i) && n < 20) begin
				n++;
				@(posedge pclk);
			end
			check(n, 32'h0000_0008);
		end
		check(32'(leds), 32'h0000_0004);
		check(32'(baud_divisor), 32'h0000_0a2c);
		check(32'({normal_mode, selftest_mode}), 32'h0000_0001);
		host.send(5'h03);
		@(posedge pclk);
		check(32'(frame_accept), 32'h0000_0000);
		apb(1'b0, 12'h004, 32'h0000_0000);
		check(q, 32'h0000_0483);
		apb(1'b1, 12'h000, 32'h0000_0000);
		@(posedge pclk);
		check(32'(leds), 32'h0000_0000);
		apb(1'b0, 12'h000, 32'h0000_0000);
		check(q, 32'h0000_0000);
		apb(1'b1, 12'h000, 32'h0000_0001);
		@(posedge pclk);
		check(32'(leds), 32'h0000_0004);
		$display("selftest test done");
	endtask
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		t_normal;
		t_selftest;
		close_out;
	end
	initial begin
		#100000;
		n_mismatch++;
		close_out;
	end
endmodule // tb_dsw_config_decoder
